// ===== rtl/dspis_pkg.sv
package dspis_pkg;

  // register port geometry
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 16;

  // register offsets
  localparam logic [15:0] ADDR_CORE_RATE  = 16'hE220;
  localparam logic [15:0] ADDR_CLK_ENABLE = 16'hF000;
  localparam logic [15:0] ADDR_CORE_RUN   = 16'hF001;
  localparam logic [15:0] ADDR_STATUS     = 16'hF002;
  localparam logic [15:0] ADDR_DIVIDER    = 16'hF003;
  localparam logic [15:0] ADDR_BOOT_CTRL  = 16'hF004;

  // reset values, and the core rate that holds off the start enable
  localparam logic [15:0] CORE_RATE_RST   = 16'h0000;
  localparam logic [15:0] CORE_RATE_HOLD  = 16'h001C;
  localparam logic [4:0]  CLK_ENABLE_RST  = 5'h1F;

  // clock enable field positions
  localparam int unsigned CLKEN_RATE_CONV = 0;
  localparam int unsigned CLKEN_RX        = 1;
  localparam int unsigned CLKEN_TX        = 2;
  localparam int unsigned CLKEN_AUX       = 3;
  localparam int unsigned CLKEN_CORE      = 4;
  localparam int unsigned SECTION_NUM     = 5;

  // status field positions
  localparam int unsigned STAT_INIT_DONE  = 0;
  localparam int unsigned STAT_BOOT_BUSY  = 1;
  localparam int unsigned STAT_CORE_START = 2;

  // init period: 2^15 divided crystal periods
  localparam int unsigned INIT_EXP        = 15;
  localparam int unsigned INIT_CYCLES     = 32768;
  localparam int unsigned DIV_CNT_W       = 8;

  // divider select pin code to divide value
  function automatic logic [7:0] dspis_div_value(input logic [2:0] code);
    case (code)
      3'd0:    dspis_div_value = 8'd1;
      3'd1:    dspis_div_value = 8'd2;
      3'd2:    dspis_div_value = 8'd4;
      3'd3:    dspis_div_value = 8'd6;
      3'd4:    dspis_div_value = 8'd8;
      default: dspis_div_value = 8'd4;
    endcase
  endfunction

  typedef enum logic [1:0] {
    DSPIS_INIT,
    DSPIS_BOOT,
    DSPIS_READY
  } dspis_state_t;

endpackage

// ===== rtl/dspis_sequencer.sv
// Added by the designer: the placing of the registers and the strobed register port.
module dspis_sequencer
  import dspis_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [2:0]        divider_select_pins_i,
  input  wire logic              port_is_i2c_i,
  input  wire logic              self_boot_i,
  input  wire logic              boot_done_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  output logic      [SECTION_NUM-1:0] section_clk_en_o,
  output logic                   core_run_o,
  output logic                   core_start_en_o,
  output logic                   init_done_o,
  output logic                   boot_start_o,
  output logic                   port_mode_i2c_o
);

  logic [2:0]             pins_meta_reg;
  logic [2:0]             pins_sync_reg;
  logic [2:0]             div_code_reg;
  logic                   rst_seen_reg;
  logic [DIV_CNT_W-1:0]   div_cnt_reg;
  logic [INIT_EXP:0]      init_cnt_reg;
  dspis_state_t           state_reg;
  logic [DATA_W-1:0]      core_rate_reg;
  logic [SECTION_NUM-1:0] clk_en_reg;
  logic                   core_run_reg;
  logic                   boot_req_reg;
  logic                   boot_start_reg;
  logic                   i2c_mode_reg;
  logic [DATA_W-1:0]      rdata_reg;
  logic                   init_done_reg;

  wire logic [7:0] div_value  = dspis_div_value(div_code_reg);
  wire logic       div_tick   = (div_cnt_reg == div_value[DIV_CNT_W-1:0]
                                 - 8'd1);
  wire logic       init_end   = init_cnt_reg[INIT_EXP];
  wire logic       ready      = (state_reg == DSPIS_READY);
  // writes before ready (during init or self-boot) are dropped; the host must wait anyway
  wire logic       wr_ok      = wr_i & ready;
  wire logic       hit_rate   = (addr_i == ADDR_CORE_RATE);
  wire logic       hit_clken  = (addr_i == ADDR_CLK_ENABLE);
  wire logic       hit_run    = (addr_i == ADDR_CORE_RUN);
  wire logic       hit_boot   = (addr_i == ADDR_BOOT_CTRL);
  wire logic       start_en   = (core_rate_reg != CORE_RATE_HOLD);
  wire logic [DATA_W-1:0] status_word = {13'h0000, start_en,
                                         state_reg == DSPIS_BOOT, ready};

  // read mux; status and divider are read-only, unmapped reads zero
  logic [DATA_W-1:0] rdata_next;
  always_comb
  begin
    rdata_next = 16'h0000;
    case (addr_i)
      ADDR_CORE_RATE:  rdata_next = core_rate_reg;
      ADDR_CLK_ENABLE: rdata_next = {11'h000, clk_en_reg};
      ADDR_CORE_RUN:   rdata_next = {15'h0000, core_run_reg};
      ADDR_STATUS:     rdata_next = status_word;
      ADDR_DIVIDER:    rdata_next = {13'h0000, div_code_reg};
      ADDR_BOOT_CTRL:  rdata_next = {15'h0000, i2c_mode_reg};
      default:         rdata_next = 16'h0000;
    endcase
  end

  // pins are asynchronous straps: two-stage sync before use
  always_ff @(posedge clk_i)
  begin
    pins_meta_reg <= divider_select_pins_i;
    pins_sync_reg <= pins_meta_reg;
  end

  // capture the strap on the first clock after reset release
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rst_seen_reg <= 1'b0;
      div_code_reg <= 3'd0;
    end
    else if (!rst_seen_reg)
    begin
      rst_seen_reg <= 1'b1;
      div_code_reg <= pins_sync_reg;
    end
  end

  // divided-crystal tick drives the init period counter
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !rst_seen_reg || div_tick)
      div_cnt_reg <= '0;
    else
      div_cnt_reg <= div_cnt_reg + 8'd1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      init_cnt_reg <= '0;
    else if (rst_seen_reg && div_tick && !init_end)
      init_cnt_reg <= init_cnt_reg + 16'd1;
  end

  // sequencer: init, optional self-boot, then ready
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_reg <= DSPIS_INIT;
    else
      case (state_reg)
        DSPIS_INIT:
          if (init_end)
            state_reg <= boot_req_reg ? DSPIS_BOOT : DSPIS_READY;
        DSPIS_BOOT:
          if (boot_done_i)
            state_reg <= DSPIS_READY;
        DSPIS_READY:
          state_reg <= DSPIS_READY;
        default:
          state_reg <= DSPIS_INIT;
      endcase
  end

  // boot and port-mode straps sampled with the divider pins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      boot_req_reg <= 1'b0;
      i2c_mode_reg <= 1'b0;
    end
    else if (!rst_seen_reg)
    begin
      boot_req_reg <= self_boot_i;
      i2c_mode_reg <= port_is_i2c_i;
    end
  end

  // one-cycle pulse to the EEPROM loader
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      boot_start_reg <= 1'b0;
    else
      boot_start_reg <= (state_reg == DSPIS_INIT) && init_end
                        && boot_req_reg;
  end

  // software-visible control registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      core_rate_reg <= CORE_RATE_RST;
      clk_en_reg    <= CLK_ENABLE_RST;
      core_run_reg  <= 1'b0;
    end
    else if (wr_ok)
    begin
      if (hit_rate)
        core_rate_reg <= wdata_i;
      if (hit_clken)
        clk_en_reg <= wdata_i[SECTION_NUM-1:0];
      if (hit_run)
        core_run_reg <= wdata_i[0];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_reg <= 16'h0000;
    else
      rdata_reg <= rd_i ? rdata_next : 16'h0000;
  end

  // ready is a state decode; registering it keeps the pin glitch-free
  // and opens it in the same cycle as the section clocks
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      init_done_reg <= 1'b0;
    else
      init_done_reg <= status_word[STAT_INIT_DONE];
  end

  // all section clocks stay blocked until ready, after init and any self-boot
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      section_clk_en_o <= '0;
      core_run_o       <= 1'b0;
      core_start_en_o  <= 1'b0;
    end
    else
    begin
      section_clk_en_o <= ready ? clk_en_reg : '0;
      core_run_o       <= ready & core_run_reg & clk_en_reg[CLKEN_CORE];
      core_start_en_o  <= ready & start_en;
    end
  end

  assign rdata_o         = rdata_reg;
  assign init_done_o     = init_done_reg;
  assign boot_start_o    = boot_start_reg;
  assign port_mode_i2c_o = i2c_mode_reg;

  wire logic unused_ok = hit_boot | status_word[STAT_CORE_START];

endmodule // dspis_sequencer

// ===== tb/dspis_sequencer_monitor.sv
module dspis_sequencer_monitor
  import dspis_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic [ADDR_W-1:0]      addr_i,
  input  wire logic [DATA_W-1:0]      wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  input  wire logic [DATA_W-1:0]      rdata_o,
  input  wire logic [SECTION_NUM-1:0] section_clk_en_o,
  input  wire logic                   core_run_o,
  input  wire logic                   core_start_en_o,
  input  wire logic                   init_done_o,
  input  wire logic                   boot_start_o,
  input  wire logic                   port_mode_i2c_o
);
  logic [16:0] up_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // cycles since reset release, saturating so it never wraps
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      up_reg <= '0;
    else if (!up_reg[16])
      up_reg <= up_reg + 17'h1;
  end

  AST_GATED_IN_INIT: assert property (!init_done_o |->
    section_clk_en_o == '0 && !core_run_o) else $error("clock open in init");
  AST_INIT_LENGTH: assert property ($rose(init_done_o) |->
    up_reg >= INIT_CYCLES) else $error("init period too short");
  AST_RDATA_ONE_CYCLE: assert property (!$past(rd_i) |->
    rdata_o == '0) else $error("read data outside its cycle");
  AST_MODE_HELD: assert property (init_done_o |->
    $stable(port_mode_i2c_o)) else $error("port mode moved");
  AST_BOOT_PULSE: assert property (boot_start_o |=>
    !boot_start_o) else $error("boot start longer than a cycle");
  AST_BOOT_BEFORE_READY: assert property (boot_start_o |->
    !init_done_o ##1 !init_done_o) else $error("ready before boot");
  AST_RUN_NEEDS_CLK: assert property (core_run_o |->
    section_clk_en_o[CLKEN_CORE]) else $error("core runs unclocked");
  AST_HOLD_START: assert property (wr_i && addr_i == ADDR_CORE_RATE &&
    wdata_i == CORE_RATE_HOLD |-> ##2 !core_start_en_o)
    else $error("start pulse not held off");
endmodule // dspis_sequencer_monitor

// ===== tb/dspis_boot_loader.sv
module dspis_boot_loader
#(
  parameter int unsigned LOAD_CYCLES = 40
)
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic boot_start_i,
  output logic      boot_done_o
);
  int unsigned left_reg;

  // eeprom transfer takes a while; done stays up as a level afterwards
  always_ff @(posedge clk_i)
  begin
    if (rst_i || boot_start_i)
      left_reg <= LOAD_CYCLES;
    else if (left_reg != 0)
      left_reg <= left_reg - 1;
  end
  assign boot_done_o = (left_reg == 0) && !rst_i && !boot_start_i;
endmodule // dspis_boot_loader

// ===== tb/dspis_sequencer_bench.sv
bind dspis_sequencer dspis_sequencer_monitor i_mon (.clk_i(clk_i),
  .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .section_clk_en_o(section_clk_en_o),
  .core_run_o(core_run_o), .core_start_en_o(core_start_en_o),
  .init_done_o(init_done_o), .boot_start_o(boot_start_o),
  .port_mode_i2c_o(port_mode_i2c_o));

module dspis_sequencer_bench
  import dspis_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk_i, rst_i, wr_i, rd_i, done, run, start_en;
  logic              ready, boot, mode;
  logic [15:0]       addr_i, wdata_i, rdata, got;
  logic [4:0]        clk_en;
  logic [2:0]        pins;
  logic              i2c, sboot;
  int                n_mismatch, check_count, t;
  // rows: address, write data, value read back; core run row comes last
  logic [47:0]       rows [7] = '{48'hF000_0015_0015, 48'hE220_0001_0001,
    48'hF002_0000_0005, 48'hF003_0007_0000, 48'hF004_0000_0001,
    48'h1234_0005_0000, 48'hF001_0001_0001};

  dspis_sequencer i_dspis_sequencer (.clk_i(clk_i), .rst_i(rst_i),
    .divider_select_pins_i(pins), .port_is_i2c_i(i2c),
    .self_boot_i(sboot), .boot_done_i(done), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata),
    .section_clk_en_o(clk_en), .core_run_o(run),
    .core_start_en_o(start_en), .init_done_o(ready),
    .boot_start_o(boot), .port_mode_i2c_o(mode));
  dspis_boot_loader i_dspis_boot_loader (.clk_i(clk_i), .rst_i(rst_i),
    .boot_start_i(boot), .boot_done_o(done));

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(logic [15:0] a, logic [15:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(logic [15:0] a);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    got = rdata;
  endtask

  // bounded wait: a hang ends the run with a mismatch
  task automatic wait_hi(bit sel, int lim);
    t = 0;
    while ((sel ? ready : boot) !== 1'b1)
    begin
      @(posedge clk_i);
      #1;
      t++;
      if (t > lim)
      begin
        chk("timeout", 16'h0001, 16'h0000);
        conclude();
      end
    end
  endtask

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  initial
  begin
    {rst_i, wr_i, rd_i, addr_i, wdata_i} = {1'b1, 34'h0};
    {pins, i2c, sboot} = {3'h0, 1'b1, 1'b1};
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_hi(1'b0, 40000);
    chk("init length", 16'h0001, 16'(t >= 32768 && t <= 32775));
    wr(ADDR_CLK_ENABLE, 16'h0000);
    #1;
    chk("gated in boot", 16'h0000, 16'(clk_en));
    wait_hi(1'b1, 200);
    rd(ADDR_CLK_ENABLE);
    chk("early write", 16'h001F, got);
    // host init sequence: hold the start pulse, stop the core first
    wr(ADDR_CORE_RATE, CORE_RATE_HOLD);
    wr(ADDR_CORE_RUN, 16'h0000);
    #1;
    chk("start held early", 16'h0000, 16'(start_en));
    $display("test init done");
    foreach (rows[i])
    begin
      wr(rows[i][47:32], rows[i][31:16]);
      rd(rows[i][47:32]);
      chk("readback", rows[i][15:0], got);
    end
    chk("section clocks", 16'h0015, 16'(clk_en));
    chk("core run", 16'h0001, 16'(run));
    chk("start enable", 16'h0001, 16'(start_en));
    chk("port mode", 16'h0001, 16'(mode));
    $display("test registers done");
    // single-word live update while the core runs, no bulk load
    wr(ADDR_CORE_RATE, CORE_RATE_HOLD);
    @(posedge clk_i);
    #1;
    chk("start held", 16'h0000, 16'(start_en));
    wr(ADDR_CLK_ENABLE, 16'h000F);
    @(posedge clk_i);
    #1;
    chk("core gated", 16'h0000, 16'(run));
    $display("test gating done");
    // mid-run reset: straps move only while reset is held
    @(posedge clk_i);
    rst_i <= 1'b1;
    pins <= 3'h4;
    i2c <= 1'b0;
    sboot <= 1'b0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk("clocks after reset", 16'h0000, 16'(clk_en));
    chk("ready after reset", 16'h0000, 16'(ready));
    chk("spi mode", 16'h0000, 16'(mode));
    rd(ADDR_DIVIDER);
    chk("divider code", 16'h0004, got);
    rd(ADDR_CORE_RATE);
    chk("rate after reset", CORE_RATE_RST, got);
    $display("test reset done");
    conclude();
  end
endmodule // dspis_sequencer_bench
